// File: instruction_sequencer_pc_stack_tb.sv
`timescale 1ns/1ns
module instruction_sequencer_pc_stack_tb;
   import seq_pkg::*;
   typedef struct packed {seq_op_e k; logic c; seq_pc_t t; seq_pc_t f; logic v;} seq_row_s;
   // Upper part cut to four bits so the mask shows on the far call
   localparam seq_row_s ROWS [16] = '{
      '{OP_SEQ, 1'h0, 13'h000, 13'h000, 1'h0}, '{OP_SEQ, 1'h0, 13'h000, 13'h001, 1'h1},
      '{OP_JUMP, 1'h0, 13'h123, 13'h002, 1'h1}, '{OP_JUMP, 1'h0, 13'h0aa, 13'h123, 1'h0},
      '{OP_CALL, 1'h0, 13'h040, 13'h124, 1'h1}, '{OP_SEQ, 1'h0, 13'h000, 13'h040, 1'h0},
      '{OP_SKIP, 1'h1, 13'h000, 13'h041, 1'h1}, '{OP_SEQ, 1'h0, 13'h000, 13'h042, 1'h0},
      '{OP_SKIP, 1'h0, 13'h000, 13'h043, 1'h1}, '{OP_SUB_RETURN, 1'h0, 13'h000, 13'h044, 1'h1},
      '{OP_SEQ, 1'h0, 13'h000, 13'h124, 1'h0}, '{OP_CALL, 1'h0, 13'h1f00, 13'h125, 1'h1},
      '{OP_SEQ, 1'h0, 13'h000, 13'h0f00, 1'h0}, '{OP_INT_RETURN, 1'h0, 13'h000, 13'h0f01, 1'h1},
      '{OP_SEQ, 1'h0, 13'h000, 13'h125, 1'h0}, '{OP_SEQ, 1'h0, 13'h000, 13'h126, 1'h1}};
   logic mclk_in = 1'h0;
   logic rst_n_in = 1'h0;
   seq_avs_req_s req = '0;
   seq_dec_s dec = '{OP_SEQ, 1'h0, 13'h000};
   logic int_req = 1'h0;
   logic [31:0] rd, rdata;
   logic wreq, ev, fs, ack, sev, sack;
   seq_pc_t fa, sfa;
   logic [3:0] ph;
   seq_instr_t ei;
   int bad_count = 0;
   int cmp_count = 0;
   int i, k;
   seq_sequencer #(.PC_HI_BITS(4)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .avs_req_in(req), .avs_readdata_out(rd), .avs_waitrequest_out(wreq),
      .instr_in({3'h5, fa}), .dec_in(dec), .int_req_in(int_req), .int_vector_in(13'h0200),
      .fetch_addr_out(fa), .fetch_strobe_out(fs), .phase_out(ph), .exec_instr_out(ei),
      .exec_valid_out(ev), .int_ack_out(ack));
   initial forever #4 mclk_in = ~mclk_in;
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task stuck;
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      test_done();
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Samples just after an instruction cycle ends, then decodes the new one
   task step(input seq_op_e kd, input logic c, input seq_pc_t t);
      seq_pc_t pfa;
      int n;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
         if (n > 16) stuck();
      end while (ph !== 4'h8);
      pfa = fa;
      #1;
      sfa = fa;
      sev = ev;
      sack = ack;
      if (sev === 1'h1) chk(ei, {3'h5, pfa});
      @(posedge mclk_in);
      dec <= '{kd, c, t};
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_in);
      req <= '{~w, w, a, d};
      do begin
         @(posedge mclk_in);
         n++;
         if (n > 16) stuck();
      end while (wreq !== 1'h0);
      rdata = rd;
      req <= '0;
   endtask
   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge mclk_in);
      #1;
      chk(ph, 4'h8);
      chk(fa, 13'h000);
      @(posedge mclk_in);
      rst_n_in <= 1'h1;
      for (i = 0; i < 16; i++) begin
         step(ROWS[i].k, ROWS[i].c, ROWS[i].t);
         chk(sfa, ROWS[i].f);
         chk(sev, ROWS[i].v);
      end
      bus(1'h0, 4'h0, 32'h0);
      chk(rdata, 32'h27);
      bus(1'h1, 4'h0, 32'h0000ab55);
      step(OP_SEQ, 1'h0, 13'h000);
      chk(sfa, 13'h155);
      chk(sev, 1'h0);
      bus(1'h0, 4'h8, 32'h0);
      chk(rdata, 32'h0);
      int_req <= 1'h1;
      step(OP_SEQ, 1'h0, 13'h000);
      chk(sack, 1'h1);
      chk(sfa, 13'h200);
      int_req <= 1'h0;
      for (i = 0; i < 8; i++) begin
         k = 0;
         do begin
            step(OP_CALL, 1'h0, seq_pc_t'(13'h300 + i));
            k++;
         end while (sev !== 1'h1 && k < 4);
      end
      step(OP_SEQ, 1'h0, 13'h000);
      chk(sfa, 13'h307);
      int_req <= 1'h1;
      for (i = 0; i < 2; i++) begin
         step(OP_SEQ, 1'h0, 13'h000);
         chk(sack, 1'h0);
      end
      bus(1'h0, 4'h4, 32'h0);
      chk(rdata[1], 1'h1);
      step(OP_SUB_RETURN, 1'h0, 13'h000);
      step(OP_SEQ, 1'h0, 13'h000);
      chk(sack, 1'h0);
      step(OP_SEQ, 1'h0, 13'h000);
      chk(sack, 1'h1);
      chk(sfa, 13'h200);
      int_req <= 1'h0;
      rst_n_in <= 1'h0;
      @(posedge mclk_in);
      #1;
      chk(fa, 13'h000);
      chk(ev, 1'h0);
      test_done();
   end
endmodule

// File: seq_pkg.sv
package seq_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int PC_MAX_W = 13;
   localparam int PC_LOW_W = 8;
   localparam int PC_HI_MAX = 5;
   localparam int INSTR_W = 16;
   localparam int STK_IDX_W = 3;

   typedef logic [PC_MAX_W-1:0] seq_pc_t;
   typedef logic [INSTR_W-1:0] seq_instr_t;

   // ------------------------------------------------------------
   // Reset values and stack
   // ------------------------------------------------------------
   localparam seq_pc_t PC_RESET_VEC = 13'h0000;
   localparam seq_pc_t PC_FULL_MASK = 13'h1fff;
   localparam logic [3:0] STACK_DEPTH = 4'h8;
   localparam logic [STK_IDX_W-1:0] STK_IDX_TOP = 3'h0;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] REG_PC_LOW_BYTE = 4'h0;
   localparam logic [3:0] REG_SEQ_STATUS = 4'h4;
   localparam int ST_EXEC_VALID_BIT = 0;
   localparam int ST_INT_WITHHELD_BIT = 1;
   localparam int ST_LOWB_PEND_BIT = 2;
   localparam int ST_PHASE_LSB = 4;

   // ------------------------------------------------------------
   // Phases and decoded operations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} seq_phase_e;

   typedef enum logic [2:0] {
      OP_SEQ, OP_JUMP, OP_CALL, OP_SUB_RETURN, OP_INT_RETURN, OP_SKIP
   } seq_op_e;

   typedef struct packed {
      seq_op_e kind;
      logic cond_met;
      seq_pc_t target;
   } seq_dec_s;

   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } seq_avs_req_s;

endpackage

// File: seq_sequencer.sv
`timescale 1ns/1ns
// How it works
// - Clock divided into four phases; one pass of four forms one instruction cycle.
// - Entering first phase the counter advances and the next word is fetched.
// - Next fetch overlaps current execution; plain instructions retire one per cycle.
// - Jumps and calls take their own cycle plus one dummy cycle.
// - Without a redirect the counter steps by one per instruction cycle.
// - Jump, call, interrupt entry and reset load the target straight into the counter.
// - A taken skip discards the prefetched word and runs a dummy cycle.
// - Counter upper part width is a build parameter of two to five bits.
// - Only the low counter byte is visible to software, read and write.
// - Writing the low byte jumps within the current 256-location page.
// - A low byte write inserts one dummy cycle for the new prefetch.
// - Return stack holds counter values only and is hidden from software.
// - Call or interrupt acknowledge pushes the counter onto the stack.
// - Subroutine or interrupt return pops the stack into the counter.
// - Reset sets the stack level index to the top of the stack.
// - With a full stack the interrupt stays requested but is not acknowledged.
// - Withheld interrupt is serviced once a return frees a stack level.
// - A call on a full stack still executes and overflows the stack.
module seq_sequencer
   import seq_pkg::*;
#(
   parameter int PC_HI_BITS = 5
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire seq_avs_req_s avs_req_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire seq_instr_t instr_in,
   input wire seq_dec_s dec_in,
   input wire logic int_req_in,
   input wire seq_pc_t int_vector_in,
   output seq_pc_t fetch_addr_out,
   output logic fetch_strobe_out,
   output logic [3:0] phase_out,
   output seq_instr_t exec_instr_out,
   output logic exec_valid_out,
   output logic int_ack_out
);

   // ------------------------------------------------------------
   // Counter width
   // ------------------------------------------------------------
   // Upper bits beyond the variant are forced to zero by masking
   localparam seq_pc_t PC_MASK = PC_FULL_MASK >> (PC_HI_MAX - PC_HI_BITS);

   function automatic logic [3:0] phase_onehot(input seq_phase_e ph);
      logic [3:0] oh;
      oh = 4'h0;
      oh[ph] = 1'b1;
      return oh;
   endfunction

   function automatic seq_pc_t pc_wrap(input seq_pc_t v);
      return v & PC_MASK;
   endfunction

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic is_branch(input seq_op_e k);
      return (k == OP_JUMP) || (k == OP_CALL);
   endfunction

   function automatic logic is_return(input seq_op_e k);
      return (k == OP_SUB_RETURN) || (k == OP_INT_RETURN);
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   seq_phase_e phase_q;
   seq_phase_e phase_d;
   seq_pc_t pc_q;
   seq_pc_t fetch_addr_q;
   logic fetch_strobe_q;
   logic [3:0] phase_oh_q;
   seq_instr_t prefetch_q;
   seq_instr_t exec_instr_q;
   logic exec_valid_q;
   logic int_ack_q;
   seq_pc_t stk_q [8];
   logic [STK_IDX_W-1:0] stk_idx_q;
   logic [3:0] stk_cnt_q;
   logic lowb_pend_q;
   logic [PC_LOW_W-1:0] lowb_data_q;
   logic primed_q;
   logic waitreq_q;
   logic [31:0] rdata_q;

   logic stk_full;
   logic redirect;
   logic do_push;
   logic do_pop;
   logic take_int;
   logic take_lowb;
   seq_pc_t next_pc;
   seq_pc_t pop_val;
   logic bus_req;
   logic bus_wr_done;
   logic [31:0] rd_mux;

   assign stk_full = (stk_cnt_q == STACK_DEPTH);
   assign pop_val = stk_q[stk_idx_q - 3'h1];

   // ------------------------------------------------------------
   // Phase sequencing
   // ------------------------------------------------------------
   always_comb begin
      case (phase_q)
         PH_T1: phase_d = PH_T2;
         PH_T2: phase_d = PH_T3;
         PH_T3: phase_d = PH_T4;
         PH_T4: phase_d = PH_T1;
         default: phase_d = PH_T1;
      endcase
   end

   // Reset parks in the last phase so the first edge starts a fetch
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_q <= PH_T4;
      end else begin
         phase_q <= phase_d;
      end
   end

   // One-hot copy keeps the phase output straight off a flip-flop
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_oh_q <= 4'h8;
      end else begin
         phase_oh_q <= phase_onehot(phase_d);
      end
   end

   // ------------------------------------------------------------
   // Redirect decision, taken at the end of the last phase
   // ------------------------------------------------------------
   // Order: executing branch, then pending low byte write, then interrupt
   always_comb begin
      redirect = 1'b0;
      do_push = 1'b0;
      do_pop = 1'b0;
      take_int = 1'b0;
      take_lowb = 1'b0;
      next_pc = pc_q;
      if (phase_q == PH_T4) begin
         if (exec_valid_q && is_branch(dec_in.kind)) begin
            redirect = 1'b1;
            next_pc = pc_wrap(dec_in.target);
            do_push = (dec_in.kind == OP_CALL);
         end else if (exec_valid_q && is_return(dec_in.kind)) begin
            redirect = 1'b1;
            do_pop = 1'b1;
            next_pc = pc_wrap(pop_val);
         end else if (exec_valid_q && dec_in.kind == OP_SKIP && dec_in.cond_met) begin
            redirect = 1'b1;
         end else if (lowb_pend_q) begin
            redirect = 1'b1;
            take_lowb = 1'b1;
            next_pc = pc_wrap({pc_q[PC_MAX_W-1:PC_LOW_W], lowb_data_q});
         end else if (int_req_in && !stk_full) begin
            // A full stack holds the acknowledge back until a return pops
            redirect = 1'b1;
            take_int = 1'b1;
            do_push = 1'b1;
            next_pc = pc_wrap(int_vector_in);
         end
      end
   end

   // ------------------------------------------------------------
   // Program counter and fetch
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_q <= PC_RESET_VEC;
      end else if (phase_q == PH_T4) begin
         pc_q <= pc_wrap(next_pc + 13'h0001);
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fetch_addr_q <= PC_RESET_VEC;
      end else if (phase_q == PH_T4) begin
         fetch_addr_q <= next_pc;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fetch_strobe_q <= 1'b0;
      end else begin
         fetch_strobe_q <= (phase_q == PH_T4);
      end
   end

   // ------------------------------------------------------------
   // Pipeline registers
   // ------------------------------------------------------------
   // Fetched word arrives in the second phase while the older one executes
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prefetch_q <= 16'h0000;
      end else if (phase_q == PH_T2) begin
         prefetch_q <= instr_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         exec_instr_q <= 16'h0000;
      end else if (phase_q == PH_T4) begin
         exec_instr_q <= prefetch_q;
      end
   end

   // Any redirect throws the prefetched word away
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         exec_valid_q <= 1'b0;
      end else if (phase_q == PH_T4) begin
         exec_valid_q <= primed_q && !redirect;
      end
   end

   // No word was fetched before reset, so the first cycle is a dummy
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         primed_q <= 1'b0;
      end else if (phase_q == PH_T4) begin
         primed_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         int_ack_q <= 1'b0;
      end else begin
         int_ack_q <= take_int;
      end
   end

   // ------------------------------------------------------------
   // Return stack
   // ------------------------------------------------------------
   // The return address is the discarded prefetch address
   generate
      for (genvar i = 0; i < 8; i++) begin : g_stk
         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               stk_q[i] <= PC_RESET_VEC;
            end else if (do_push && stk_idx_q == STK_IDX_W'(i)) begin
               stk_q[i] <= fetch_addr_q;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stk_idx_q <= STK_IDX_TOP;
      end else if (do_push) begin
         // Index wraps so the oldest entry is lost on overflow
         stk_idx_q <= stk_idx_q + 3'h1;
      end else if (do_pop) begin
         stk_idx_q <= stk_idx_q - 3'h1;
      end
   end

   // Count saturates at the depth; it only gates interrupt entry
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stk_cnt_q <= 4'h0;
      end else if (do_push && !stk_full) begin
         stk_cnt_q <= stk_cnt_q + 4'h1;
      end else if (do_pop && stk_cnt_q != 4'h0) begin
         stk_cnt_q <= stk_cnt_q - 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------
   // One wait cycle per access; data and effect land on the answer edge
   assign bus_req = avs_req_in.read || avs_req_in.write;
   assign bus_wr_done = avs_req_in.write && !waitreq_q &&
                        (avs_req_in.address == REG_PC_LOW_BYTE);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_req_in.address)
         REG_PC_LOW_BYTE: rd_mux[PC_LOW_W-1:0] = pc_q[PC_LOW_W-1:0];
         REG_SEQ_STATUS: begin
            // Stack contents and index stay hidden
            rd_mux[ST_EXEC_VALID_BIT] = exec_valid_q;
            rd_mux[ST_INT_WITHHELD_BIT] = int_req_in && stk_full;
            rd_mux[ST_LOWB_PEND_BIT] = lowb_pend_q;
            rd_mux[ST_PHASE_LSB +: 4] = phase_oh_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waitreq_q <= 1'b1;
      end else begin
         waitreq_q <= !(bus_req && waitreq_q);
      end
   end

   // ------------------------------------------------------------
   // Read data and low byte write
   // ------------------------------------------------------------
   // Read data is caught at the taking edge and stands until the next read
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_req_in.read && waitreq_q) begin
         rdata_q <= rd_mux;
      end
   end

   // A new write in the cycle a pending one is consumed keeps it pending
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lowb_pend_q <= 1'b0;
      end else if (bus_wr_done) begin
         lowb_pend_q <= 1'b1;
      end else if (take_lowb) begin
         lowb_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lowb_data_q <= 8'h00;
      end else if (bus_wr_done) begin
         lowb_data_q <= avs_req_in.writedata[PC_LOW_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign avs_readdata_out = rdata_q;
   assign avs_waitrequest_out = waitreq_q;
   assign fetch_addr_out = fetch_addr_q;
   assign fetch_strobe_out = fetch_strobe_q;
   assign phase_out = phase_oh_q;
   assign exec_instr_out = exec_instr_q;
   assign exec_valid_out = exec_valid_q;
   assign int_ack_out = int_ack_q;

endmodule

// File: seq_sequencer_chk.sv
`timescale 1ns/1ns
module seq_sequencer_chk
   import seq_pkg::*;
#(
   parameter int PC_HI_BITS = 5
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire seq_avs_req_s avs_req_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire seq_instr_t instr_in,
   input wire seq_dec_s dec_in,
   input wire logic int_req_in,
   input wire seq_pc_t int_vector_in,
   input wire seq_pc_t fetch_addr_out,
   input wire logic fetch_strobe_out,
   input wire logic [3:0] phase_out,
   input wire seq_instr_t exec_instr_out,
   input wire logic exec_valid_out,
   input wire logic int_ack_out
);
   localparam seq_pc_t MASK = seq_pc_t'((1 << (8 + PC_HI_BITS)) - 1);
   seq_pc_t tgt_q;
   seq_pc_t vec_q;
   logic pend_q;
   logic run;
   logic seq_end;
   assign run = phase_out[3] && exec_valid_out;
   assign seq_end = phase_out[3] && (!exec_valid_out || dec_in.kind == OP_SEQ);
   // Pending low byte write overrides a plain step, so step checks skip it
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tgt_q <= '0;
         vec_q <= '0;
         pend_q <= 1'h0;
      end else begin
         tgt_q <= dec_in.target & MASK;
         vec_q <= int_vector_in & MASK;
         if (avs_req_in.write && !avs_waitrequest_out && avs_req_in.address == 4'h0) begin
            pend_q <= 1'h1;
         end else if (seq_end) begin
            pend_q <= 1'h0;
         end
      end
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_phase_onehot: assert property ($onehot(phase_out))
      else $error("phase not one-hot");
   a_phase_wrap: assert property (phase_out[3] |=> phase_out == 4'h1)
      else $error("phase wrap wrong");
   a_strobe_t1: assert property (fetch_strobe_out |-> phase_out[0] ##1
      !fetch_strobe_out [*3] ##1 fetch_strobe_out)
      else $error("strobe not once per cycle");
   a_fetch_hold: assert property (!phase_out[3] |=>
      $stable(fetch_addr_out) && $stable(exec_instr_out))
      else $error("fetch moved mid cycle");
   a_pc_step: assert property (run && dec_in.kind == OP_SEQ &&
      !int_req_in && !pend_q |=>
      fetch_addr_out == (($past(fetch_addr_out) + 13'h0001) & MASK))
      else $error("counter did not step");
   a_branch_load: assert property (run &&
      (dec_in.kind == OP_JUMP || dec_in.kind == OP_CALL) |=>
      fetch_addr_out == tgt_q && !exec_valid_out)
      else $error("branch target wrong");
   a_skip_dummy: assert property (run && dec_in.kind == OP_SKIP && dec_in.cond_met |=>
      !exec_valid_out && fetch_addr_out == (($past(fetch_addr_out) + 13'h0001) & MASK))
      else $error("skip not dummied");
   a_addr_mask: assert property ((fetch_addr_out & ~MASK) == 13'h0000)
      else $error("upper bits set");
   a_bus_wait: assert property ((avs_req_in.read || avs_req_in.write) &&
      avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus answer wrong");
   a_int_vector: assert property (int_ack_out |-> fetch_strobe_out && fetch_addr_out == vec_q)
      else $error("vector fetch wrong");
endmodule
bind seq_sequencer seq_sequencer_chk #(.PC_HI_BITS(PC_HI_BITS)) u_chk (.mclk_in(mclk_in),
   .rst_n_in(rst_n_in), .avs_req_in(avs_req_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .instr_in(instr_in), .dec_in(dec_in),
   .int_req_in(int_req_in), .int_vector_in(int_vector_in), .fetch_addr_out(fetch_addr_out),
   .fetch_strobe_out(fetch_strobe_out), .phase_out(phase_out),
   .exec_instr_out(exec_instr_out), .exec_valid_out(exec_valid_out), .int_ack_out(int_ack_out));
